// ==== include/cs_timing_params.svh ====
// Purpose: Constants for the chip select timing configuration registers.
// Assumes: Included by its bare name from design and bench files.
// Notes: Offsets are byte addresses on the plain register port.
`ifndef CS_TIMING_PARAMS_SVH
`define CS_TIMING_PARAMS_SVH

// ----------------------------------------------------------------------
// Register port geometry
// ----------------------------------------------------------------------
`define CS_ADDR_W 8
`define CS_DATA_W 32
`define CS_SELECTS 4

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define CS_DYN_LATENCY_BASE 8'h00
`define CS_STATIC_SETUP_BASE 8'h20
`define CS_STATUS_OFFSET 8'h40
`define CS_GROUP_MSB 7
`define CS_GROUP_LSB 5
`define CS_INDEX_MSB 3
`define CS_INDEX_LSB 2
`define CS_GROUP_DYN 3'h0
`define CS_GROUP_STATIC 3'h1

// ----------------------------------------------------------------------
// Dynamic latency fields and reset values
// ----------------------------------------------------------------------
`define CS_CAS_MSB 10
`define CS_CAS_LSB 7
`define CS_CAS_UPPER_LSB 8
`define CS_RAS_MSB 3
`define CS_RAS_LSB 0
`define CS_CAS_RESET 4'hf
`define CS_CAS5_LOW_RESET 1'h1
`define CS_RAS_RESET 4'h3
`define CS_LATENCY_RESERVED 4'h0
`define CS_STRAP_DYN_INDEX 1

// ----------------------------------------------------------------------
// Static setup fields and reset values
// ----------------------------------------------------------------------
`define CS_PROTECT_BIT 20
`define CS_EXT_WAIT_BIT 8
`define CS_LANE_MODE_BIT 7
`define CS_POLARITY_BIT 6
`define CS_NAND_BIT 4
`define CS_PAGE_BIT 3
`define CS_WIDTH_MSB 1
`define CS_WIDTH_LSB 0
`define CS_WIDTH_RESET 2'h0
`define CS_WIDTH_RESERVED 2'h3
`define CS_STRAP_STATIC_INDEX 1

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define CS_ST_CAS_LSB 0
`define CS_ST_RAS_LSB 4
`define CS_ST_WIDTH_LSB 8
`define CS_ST_CONFLICT_LSB 12
`define CS_ST_STRAP_BIT 16

`endif

// ==== include/cs_timing_pkg.sv ====
// Purpose: Types shared by the chip select timing configuration registers.
// Assumes: Used only by scoped names, never imported.
// Notes: Field widths follow the register layouts.
package cs_timing_pkg;

    // ------------------------------------------------------------------
    // Dynamic latency setting of one chip select
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] cas;
        logic [3:0] ras;
    } dyn_latency_s;

    // ------------------------------------------------------------------
    // Static setup of one chip select
    // ------------------------------------------------------------------
    typedef struct packed {
        logic write_protect;
        logic extended_wait_enable;
        logic byte_lane_read_strobe_mode;
        logic chip_select_polarity;
        logic flash_type_select;
        logic page_burst_enable;
        logic [1:0] bus_width_select;
    } static_setup_s;

    // ------------------------------------------------------------------
    // One request on the register port
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } reg_req_s;

    // ------------------------------------------------------------------
    // Strap pins as one group
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] dyn5_cas_upper;
        logic lane1;
        logic [3:0] polarity;
        logic [1:0] width1;
    } strap_s;

endpackage

// ==== verilog/reset_release.sv ====
// Purpose: Releases an asynchronous active low reset through two flops.
// Assumes: The clock runs while the reset is asserted or soon after.
// Notes: Assertion is immediate, release is synchronous.
`timescale 1ns/1ns
`default_nettype none

module reset_release
(
    input wire logic core_clk,
    input wire logic raw_rst_n,
    output logic sync_rst_n
);

    logic stage_reg;

    // Two flops shift a one in after the reset pin goes high.
    always_ff @(posedge core_clk or negedge raw_rst_n)
    begin
        if (!raw_rst_n)
        begin
            stage_reg <= 1'b0;
            sync_rst_n <= 1'b0;
        end
        else
        begin
            stage_reg <= 1'b1;
            sync_rst_n <= stage_reg;
        end
    end

endmodule
`default_nettype wire

// ==== verilog/pin_sync.sv ====
// Purpose: Two flop synchroniser for a group of slow pin levels.
// Assumes: Each bit is a static level such as a strap.
// Notes: Only the second flop is read outside this module.
`timescale 1ns/1ns
`default_nettype none

module pin_sync
#(
    parameter int WIDTH = 10
)
(
    input wire logic core_clk,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);

    logic [WIDTH-1:0] first_reg;

    // Strap levels carry no reset; they settle long before use.
    always_ff @(posedge core_clk)
    begin
        first_reg <= pin_in;
        pin_out <= first_reg;
    end

endmodule
`default_nettype wire

// ==== verilog/cs_timing_regs.sv ====
// Purpose: Per chip select latency and static setup registers.
// Assumes: Straps hold steady around the power-on reset release.
// Notes: Settings reset only on power-on; the bus reset clears the port.
`timescale 1ns/1ns
`default_nettype none
`include "cs_timing_params.svh"

module cs_timing_regs
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic power_on_reset_n,
    input wire logic [`CS_ADDR_W-1:0] reg_addr,
    input wire logic [`CS_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`CS_DATA_W-1:0] reg_rdata,
    input wire logic [2:0] dyn_select5_latency_strap,
    input wire logic static_select1_lane_strap,
    input wire logic [`CS_SELECTS-1:0] static_select_polarity_strap,
    input wire logic [1:0] static_select1_width_strap,
    output cs_timing_pkg::dyn_latency_s [`CS_SELECTS-1:0] dyn_latency,
    output cs_timing_pkg::static_setup_s [`CS_SELECTS-1:0] static_setup,
    output logic [`CS_SELECTS-1:0] write_block,
    output logic [`CS_SELECTS-1:0] use_long_wait,
    output logic [`CS_SELECTS-1:0] read_lanes_low,
    output logic [`CS_SELECTS-1:0] nand_select,
    output logic [`CS_SELECTS-1:0] cas_code_fault,
    output logic [`CS_SELECTS-1:0] ras_code_fault,
    output logic [`CS_SELECTS-1:0] width_code_fault,
    output logic [`CS_SELECTS-1:0] wait_mode_conflict
);

    // ------------------------------------------------------------------
    // Reset release and strap synchronisation
    // ------------------------------------------------------------------
    logic bus_rst_n;
    logic por_rst_n;
    logic [9:0] strap_raw;
    logic [9:0] strap_bits;
    cs_timing_pkg::strap_s strap;

    reset_release bus_reset_release
    (
        .core_clk(core_clk),
        .raw_rst_n(arst_n),
        .sync_rst_n(bus_rst_n)
    );

    reset_release por_reset_release
    (
        .core_clk(core_clk),
        .raw_rst_n(power_on_reset_n),
        .sync_rst_n(por_rst_n)
    );

    // Strap pins are gathered and passed through two flops.
    assign strap_raw = {dyn_select5_latency_strap, static_select1_lane_strap,
                        static_select_polarity_strap,
                        static_select1_width_strap};

    pin_sync #(.WIDTH(10)) strap_sync
    (
        .core_clk(core_clk),
        .pin_in(strap_raw),
        .pin_out(strap_bits)
    );

    assign strap = cs_timing_pkg::strap_s'(strap_bits);

    // ------------------------------------------------------------------
    // Register port: one registered wait state
    // ------------------------------------------------------------------
    cs_timing_pkg::reg_req_s req;
    logic [2:0] req_group;
    logic [1:0] req_index;
    logic req_aligned;
    logic hit_dyn;
    logic hit_static;
    logic hit_status;
    logic [`CS_SELECTS-1:0] dyn_wr;
    logic [`CS_SELECTS-1:0] static_wr;
    logic [`CS_DATA_W-1:0] read_word;
    logic [`CS_DATA_W-1:0] dyn_word [`CS_SELECTS];
    logic [`CS_DATA_W-1:0] static_word [`CS_SELECTS];
    logic [`CS_DATA_W-1:0] status_word;
    logic strap_loaded_reg;
    logic strap_load;

    assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
    assign req_group = req.addr[`CS_GROUP_MSB:`CS_GROUP_LSB];
    assign req_index = req.addr[`CS_INDEX_MSB:`CS_INDEX_LSB];

    // Address decode; the lower byte bits and bit 4 must be zero.
    assign req_aligned = (req.addr[1:0] == 2'h0) && !req.addr[4];
    assign hit_dyn = req_aligned && (req_group == `CS_GROUP_DYN);
    assign hit_static = req_aligned && (req_group == `CS_GROUP_STATIC);
    assign hit_status = (req.addr == `CS_STATUS_OFFSET);

    // Read mux; unmapped addresses read as zero.
    assign read_word = hit_dyn ? dyn_word[req_index] :
                       hit_static ? static_word[req_index] :
                       hit_status ? status_word : '0;

    // Strap values are taken on the first edge after power-on release.
    assign strap_load = !strap_loaded_reg;

    always_ff @(posedge core_clk or negedge por_rst_n)
    begin
        if (!por_rst_n)
        begin
            strap_loaded_reg <= 1'b0;
        end
        else
        begin
            strap_loaded_reg <= 1'b1;
        end
    end

    // Read data appear in the cycle after the strobe and only then.
    always_ff @(posedge core_clk or negedge bus_rst_n)
    begin
        if (!bus_rst_n)
        begin
            reg_rdata <= '0;
        end
        else
        begin
            reg_rdata <= req.rd ? read_word : '0;
        end
    end

    // ------------------------------------------------------------------
    // Per chip select register copies
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `CS_SELECTS; gi = gi + 1)
        begin : g_sel
            localparam bit IS_STRAP_DYN = (gi == `CS_STRAP_DYN_INDEX);
            localparam bit IS_STRAP_ST = (gi == `CS_STRAP_STATIC_INDEX);
            cs_timing_pkg::dyn_latency_s dyn_reg;
            cs_timing_pkg::static_setup_s st_reg;
            cs_timing_pkg::dyn_latency_s dyn_next;
            cs_timing_pkg::static_setup_s st_next;

            // Writes land at the end of the strobe cycle.
            assign dyn_wr[gi] = req.wr && hit_dyn && (req_index == 2'(gi));
            assign static_wr[gi] = req.wr && hit_static
                                   && (req_index == 2'(gi));

            // Only defined fields are taken from the write data.
            assign dyn_next.cas = req.wdata[`CS_CAS_MSB:`CS_CAS_LSB];
            assign dyn_next.ras = req.wdata[`CS_RAS_MSB:`CS_RAS_LSB];
            assign st_next.write_protect = req.wdata[`CS_PROTECT_BIT];
            assign st_next.extended_wait_enable = req.wdata[`CS_EXT_WAIT_BIT];
            assign st_next.byte_lane_read_strobe_mode =
                req.wdata[`CS_LANE_MODE_BIT];
            assign st_next.chip_select_polarity = req.wdata[`CS_POLARITY_BIT];
            assign st_next.flash_type_select = req.wdata[`CS_NAND_BIT];
            assign st_next.page_burst_enable = req.wdata[`CS_PAGE_BIT];
            assign st_next.bus_width_select =
                req.wdata[`CS_WIDTH_MSB:`CS_WIDTH_LSB];

            // Latency copy; the bus reset leaves it untouched.
            always_ff @(posedge core_clk or negedge por_rst_n)
            begin
                if (!por_rst_n)
                begin
                    dyn_reg.cas <= IS_STRAP_DYN ?
                        {3'h0, `CS_CAS5_LOW_RESET} : `CS_CAS_RESET;
                    dyn_reg.ras <= `CS_RAS_RESET;
                end
                else if (dyn_wr[gi])
                begin
                    dyn_reg <= dyn_next;
                end
                else if (strap_load && IS_STRAP_DYN)
                begin
                    dyn_reg.cas[3:1] <= strap.dyn5_cas_upper;
                end
            end

            // Static setup copy; strap fields load once after power-on.
            always_ff @(posedge core_clk or negedge por_rst_n)
            begin
                if (!por_rst_n)
                begin
                    st_reg <= '0;
                    st_reg.bus_width_select <= `CS_WIDTH_RESET;
                end
                else if (static_wr[gi])
                begin
                    st_reg <= st_next;
                end
                else if (strap_load)
                begin
                    st_reg.chip_select_polarity <= strap.polarity[gi];
                    if (IS_STRAP_ST)
                    begin
                        st_reg.byte_lane_read_strobe_mode <= strap.lane1;
                        st_reg.bus_width_select <= strap.width1;
                    end
                end
            end

            // Readback places each field at its own bit position.
            always_comb
            begin
                dyn_word[gi] = '0;
                dyn_word[gi][`CS_CAS_MSB:`CS_CAS_LSB] = dyn_reg.cas;
                dyn_word[gi][`CS_RAS_MSB:`CS_RAS_LSB] = dyn_reg.ras;
                static_word[gi] = '0;
                static_word[gi][`CS_PROTECT_BIT] = st_reg.write_protect;
                static_word[gi][`CS_EXT_WAIT_BIT] =
                    st_reg.extended_wait_enable;
                static_word[gi][`CS_LANE_MODE_BIT] =
                    st_reg.byte_lane_read_strobe_mode;
                static_word[gi][`CS_POLARITY_BIT] =
                    st_reg.chip_select_polarity;
                static_word[gi][`CS_NAND_BIT] = st_reg.flash_type_select;
                static_word[gi][`CS_PAGE_BIT] = st_reg.page_burst_enable;
                static_word[gi][`CS_WIDTH_MSB:`CS_WIDTH_LSB] =
                    st_reg.bus_width_select;
            end

            // Settings and their decoded controls for the sequencers.
            always_ff @(posedge core_clk or negedge por_rst_n)
            begin
                if (!por_rst_n)
                begin
                    dyn_latency[gi] <= '0;
                    static_setup[gi] <= '0;
                    write_block[gi] <= 1'b0;
                    use_long_wait[gi] <= 1'b0;
                    read_lanes_low[gi] <= 1'b0;
                    nand_select[gi] <= 1'b0;
                    cas_code_fault[gi] <= 1'b0;
                    ras_code_fault[gi] <= 1'b0;
                    width_code_fault[gi] <= 1'b0;
                    wait_mode_conflict[gi] <= 1'b0;
                end
                else
                begin
                    dyn_latency[gi] <= dyn_reg;
                    static_setup[gi] <= st_reg;
                    write_block[gi] <= st_reg.write_protect;
                    use_long_wait[gi] <= st_reg.extended_wait_enable;
                    read_lanes_low[gi] <=
                        st_reg.byte_lane_read_strobe_mode;
                    nand_select[gi] <= st_reg.flash_type_select;
                    cas_code_fault[gi] <=
                        (dyn_reg.cas == `CS_LATENCY_RESERVED);
                    ras_code_fault[gi] <=
                        (dyn_reg.ras == `CS_LATENCY_RESERVED);
                    width_code_fault[gi] <=
                        (st_reg.bus_width_select == `CS_WIDTH_RESERVED);
                    wait_mode_conflict[gi] <= st_reg.extended_wait_enable
                        && st_reg.page_burst_enable;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Status word built from the registered fault flags and the strap loaded flag
    // ------------------------------------------------------------------
    always_comb
    begin
        status_word = '0;
        status_word[`CS_ST_CAS_LSB+:`CS_SELECTS] = cas_code_fault;
        status_word[`CS_ST_RAS_LSB+:`CS_SELECTS] = ras_code_fault;
        status_word[`CS_ST_WIDTH_LSB+:`CS_SELECTS] = width_code_fault;
        status_word[`CS_ST_CONFLICT_LSB+:`CS_SELECTS] = wait_mode_conflict;
        status_word[`CS_ST_STRAP_BIT] = strap_loaded_reg;
    end

endmodule
`default_nettype wire

// ==== verification/cs_timing_regs_assertions.sv ====
// Purpose: Concurrent checks on the chip select timing register block.
// Assumes: Sees only the block ports; one clock domain.
// Notes: A setting reaches its output two edges after the write strobe.
`timescale 1ns/1ns
`default_nettype none
`include "cs_timing_params.svh"

module cs_timing_regs_assertions
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic power_on_reset_n,
    input wire logic [`CS_ADDR_W-1:0] reg_addr,
    input wire logic [`CS_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`CS_DATA_W-1:0] reg_rdata,
    input wire logic [2:0] dyn_select5_latency_strap,
    input wire logic static_select1_lane_strap,
    input wire logic [`CS_SELECTS-1:0] static_select_polarity_strap,
    input wire logic [1:0] static_select1_width_strap,
    input wire cs_timing_pkg::dyn_latency_s [`CS_SELECTS-1:0] dyn_latency,
    input wire cs_timing_pkg::static_setup_s [`CS_SELECTS-1:0] static_setup,
    input wire logic [`CS_SELECTS-1:0] write_block,
    input wire logic [`CS_SELECTS-1:0] use_long_wait,
    input wire logic [`CS_SELECTS-1:0] read_lanes_low,
    input wire logic [`CS_SELECTS-1:0] nand_select,
    input wire logic [`CS_SELECTS-1:0] cas_code_fault,
    input wire logic [`CS_SELECTS-1:0] ras_code_fault,
    input wire logic [`CS_SELECTS-1:0] width_code_fault,
    input wire logic [`CS_SELECTS-1:0] wait_mode_conflict
);
    // All checks use the core clock and sleep during power-on reset.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!power_on_reset_n);

    AST_RDATA_SLOT: assert property (
        !$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data outside its one slot");
    AST_READ_DYN1: assert property (
        reg_rd && reg_addr == 8'h04 |=> reg_rdata ==
        {21'h0, dyn_latency[1].cas, 3'h0, dyn_latency[1].ras})
        else $error("latency read does not match setting");
    AST_PROTECT: assert property (
        reg_wr && reg_addr == 8'h20 |-> ##2
        write_block[0] == $past(reg_wdata[20], 2))
        else $error("write block not following protect bit");
    AST_LONG_WAIT: assert property (
        reg_wr && reg_addr == 8'h24 |-> ##2
        use_long_wait[1] == $past(reg_wdata[8], 2))
        else $error("long wait not following its bit");
    AST_LANES: assert property (
        reg_wr && reg_addr == 8'h28 |-> ##2
        read_lanes_low[2] == $past(reg_wdata[7], 2))
        else $error("read lane mode not following its bit");
    AST_NAND: assert property (
        reg_wr && reg_addr == 8'h2c |-> ##2
        nand_select[3] == $past(reg_wdata[4], 2))
        else $error("flash type not following its bit");
    AST_CAS_CODE: assert property (
        reg_wr && reg_addr == 8'h00 |-> ##2
        cas_code_fault[0] == ($past(reg_wdata[10:7], 2) == 4'h0))
        else $error("reserved cas code flag wrong");
    AST_RAS_CODE: assert property (
        reg_wr && reg_addr == 8'h04 |-> ##2
        ras_code_fault[1] == ($past(reg_wdata[3:0], 2) == 4'h0))
        else $error("reserved ras code flag wrong");
    AST_WIDTH: assert property (
        reg_wr && reg_addr == 8'h20 |-> ##2
        static_setup[0].bus_width_select == $past(reg_wdata[1:0], 2))
        else $error("bus width not following its field");
    AST_CONFLICT: assert property (
        reg_wr && reg_addr == 8'h2c |-> ##2 wait_mode_conflict[3] ==
        ($past(reg_wdata[8], 2) && $past(reg_wdata[3], 2)))
        else $error("wait mode conflict flag wrong");
    AST_BUS_RESET: assert property (
        !arst_n |=> $stable(static_setup) && $stable(dyn_latency))
        else $error("bus reset disturbed a setting");
endmodule

bind cs_timing_regs cs_timing_regs_assertions i_cs_timing_regs_assertions
(
    .core_clk(core_clk), .arst_n(arst_n),
    .power_on_reset_n(power_on_reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .dyn_select5_latency_strap(dyn_select5_latency_strap),
    .static_select1_lane_strap(static_select1_lane_strap),
    .static_select_polarity_strap(static_select_polarity_strap),
    .static_select1_width_strap(static_select1_width_strap),
    .dyn_latency(dyn_latency), .static_setup(static_setup),
    .write_block(write_block), .use_long_wait(use_long_wait),
    .read_lanes_low(read_lanes_low), .nand_select(nand_select),
    .cas_code_fault(cas_code_fault), .ras_code_fault(ras_code_fault),
    .width_code_fault(width_code_fault),
    .wait_mode_conflict(wait_mode_conflict)
);
`default_nettype wire

// ==== verification/strap_pins_model.sv ====
// Purpose: Board strap levels seen by the register block.
// Assumes: Straps are tied on the board and never move.
// Notes: Values come from parameters so the bench knows them.
`timescale 1ns/1ns
`default_nettype none

module strap_pins_model
#(
    parameter logic [2:0] DYN5 = 3'h5,
    parameter logic LANE1 = 1'h1,
    parameter logic [3:0] POL = 4'ha,
    parameter logic [1:0] WIDTH1 = 2'h2
)
(
    output logic [2:0] dyn_select5_latency_strap,
    output logic static_select1_lane_strap,
    output logic [3:0] static_select_polarity_strap,
    output logic [1:0] static_select1_width_strap
);
    // Fixed levels, steady long before power-on reset ends.
    assign dyn_select5_latency_strap = DYN5;
    assign static_select1_lane_strap = LANE1;
    assign static_select_polarity_strap = POL;
    assign static_select1_width_strap = WIDTH1;
endmodule
`default_nettype wire

// ==== verification/test_chip_select_timing_config_regs.sv ====
// Purpose: Self-checking bench for the chip select timing registers.
// Assumes: Register port with read data in the cycle after the strobe.
// Notes: Expected values are built from the field layout and straps.
`timescale 1ns/1ns
`default_nettype none

module test_chip_select_timing_config_regs;
    localparam logic [2:0] S_DYN5 = 3'h5;
    localparam logic S_LANE = 1'h1;
    localparam logic [3:0] S_POL = 4'ha;
    localparam logic [1:0] S_W1 = 2'h2;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic power_on_reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [2:0] dyn5_strap;
    logic lane_strap;
    logic [3:0] pol_strap;
    logic [1:0] w1_strap;
    cs_timing_pkg::dyn_latency_s [3:0] dyn_latency;
    cs_timing_pkg::static_setup_s [3:0] static_setup;
    logic [3:0] write_block, use_long_wait, read_lanes_low, nand_select;
    logic [3:0] cas_fault, ras_fault, width_fault, conflict;
    int error_cnt = 0;
    int n_tests = 0;
    // Selects 0 to 2 keep extended wait and paging apart; select 3
    // sets both on purpose so that the conflict flag is exercised.
    logic [31:0] sval [4] = '{32'h0010_0041, 32'h0000_0102,
        32'h0000_0090, 32'h0000_010b};

    // Clock of 100 ns period.
    always #50 core_clk = ~core_clk;

    strap_pins_model #(.DYN5(S_DYN5), .LANE1(S_LANE), .POL(S_POL),
        .WIDTH1(S_W1)) i_strap_pins_model (
        .dyn_select5_latency_strap(dyn5_strap),
        .static_select1_lane_strap(lane_strap),
        .static_select_polarity_strap(pol_strap),
        .static_select1_width_strap(w1_strap));

    cs_timing_regs i_cs_timing_regs (
        .core_clk(core_clk), .arst_n(arst_n),
        .power_on_reset_n(power_on_reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .dyn_select5_latency_strap(dyn5_strap),
        .static_select1_lane_strap(lane_strap),
        .static_select_polarity_strap(pol_strap),
        .static_select1_width_strap(w1_strap),
        .dyn_latency(dyn_latency), .static_setup(static_setup),
        .write_block(write_block), .use_long_wait(use_long_wait),
        .read_lanes_low(read_lanes_low), .nand_select(nand_select),
        .cas_code_fault(cas_fault), .ras_code_fault(ras_fault),
        .width_code_fault(width_fault), .wait_mode_conflict(conflict));

    // Compares one value and counts the outcome.
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // One write cycle; callers never start another write at once.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // One read cycle; data are looked at mid-way through its slot.
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        check($sformatf("register %h", a), reg_rdata, exp);
        @(posedge core_clk);
    endtask

    // Power-on values: strap fields for the strapped copies only.
    function automatic logic [31:0] dyn_rst(input int i);
        logic [3:0] cas;
        cas = (i == 1) ? {S_DYN5, 1'b1} : 4'hf;
        return {21'h0, cas, 3'h0, 4'h3};
    endfunction

    function automatic logic [31:0] st_rst(input int i);
        logic [31:0] v;
        v = {25'h0, S_POL[i], 6'h0};
        if (i == 1)
            v = v | {24'h0, S_LANE, 5'h0, S_W1};
        return v;
    endfunction

    // Full power-on reset together with the bus reset.
    task automatic do_por();
        power_on_reset_n <= 1'b0;
        arst_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        power_on_reset_n <= 1'b1;
        arst_n <= 1'b1;
        repeat (5) @(posedge core_clk);
    endtask

    task automatic check_resets();
        for (int i = 0; i < 4; i++)
        begin
            rd(8'(4 * i), dyn_rst(i));
            rd(8'(8'h20 + 4 * i), st_rst(i));
        end
    endtask

    task automatic final_report();
        if (error_cnt == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Main sequence.
    initial
    begin
        do_por();
        check_resets();
        rd(8'h40, 32'h0001_0000);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'(4 * i),
               32'hffff_f870 | 32'((i + 1) << 7) | 32'(15 - i));
            rd(8'(4 * i), 32'((i + 1) << 7) | 32'(15 - i));
            wr(8'(8'h20 + 4 * i), 32'hffef_fe24 | sval[i]);
            rd(8'(8'h20 + 4 * i), sval[i]);
        end
        // Outputs are looked at mid-cycle, away from the launching edge.
        @(negedge core_clk);
        check("write block", {28'h0, write_block}, 32'h1);
        check("long wait", {28'h0, use_long_wait}, 32'ha);
        check("read lanes", {28'h0, read_lanes_low}, 32'h4);
        check("nand", {28'h0, nand_select}, 32'h4);
        check("width", 32'(static_setup[1].bus_width_select), 32'h2);
        check("width fault", {28'h0, width_fault}, 32'h8);
        @(posedge core_clk);
        rd(8'h40, 32'h0001_8800);
        wr(8'h08, 32'h0);
        // Fault flags are registered and show one cycle after the write.
        @(posedge core_clk);
        rd(8'h40, 32'h0001_8844);
        @(negedge core_clk);
        check("cas fault", {28'h0, cas_fault}, 32'h4);
        check("ras fault", {28'h0, ras_fault}, 32'h4);
        @(posedge core_clk);
        wr(8'h50, 32'hffff_ffff);
        rd(8'h50, 32'h0);
        rd(8'h30, 32'h0);
        arst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(8'h24, sval[1]);
        rd(8'h04, 32'h0000_010e);
        do_por();
        check_resets();
        final_report();
    end

    // Cuts a hung run short.
    initial
    begin
        repeat (2000) @(posedge core_clk);
        error_cnt++;
        final_report();
    end
endmodule
`default_nettype wire
